/* design/dlp_core.sv */
`timescale 1ns/10ps
`default_nettype none
module dlp_core #(
  parameter int unsigned MIN_LOWPOWER_CYC = dlp_pkg::MIN_LOWPOWER_CYC
) (
  input  wire logic SYS_CLK_I,        // system clock 20 MHz
  input  wire logic RST_N_I,          // synchronous reset, active low
  input  wire logic LINK_CLK_I,       // memory clock from controller
  input  wire logic CKE_I,            // clock enable
  input  wire logic CS_N_I,           // chip select, active low
  input  wire logic RAS_N_I,          // row strobe, active low
  input  wire logic CAS_N_I,          // column strobe, active low
  input  wire logic WE_N_I,           // write strobe, active low
  input  wire logic TERM_EN_I,        // termination enable pin
  input  wire logic PD_EXIT_SEL_I,    // mode bit: 1 slow active exit
  input  wire logic ROW_OPEN_I,       // any bank has an open row
  output logic [2:0] STATE_O,         // low-power state code
  output logic      DLL_EN_O,         // delay-locked loop running
  output logic      INT_CLK_EN_O,     // internal clock gate open
  output logic      BUF_EN_O,         // input and output buffers on
  output logic      INT_REFRESH_O,    // internal refresh pulse
  output logic      CMD_ALLOWED_O,    // valid commands accepted
  output logic      READ_ALLOWED_O,   // read commands accepted
  output logic      CMD_ERR_O,        // illegal command seen, sticky
  output logic      REINIT_REQ_O      // contents lost, sticky
);

  localparam int unsigned IREF_CYC = MIN_LOWPOWER_CYC / 2; // falls inside the residence
  if (MIN_LOWPOWER_CYC < 2 || MIN_LOWPOWER_CYC >= (1 << dlp_pkg::CNT_W))
  begin
    $error("MIN_LOWPOWER_CYC out of range");
  end

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers for the pins

  logic [1:0] s1_ff;
  logic [1:0] s2_ff;
  logic [4:0] c1_ff;
  logic [4:0] c2_ff;
  logic       clk_prev_ff;
  always_ff @(posedge SYS_CLK_I)
  begin
    s1_ff       <= {LINK_CLK_I, CKE_I};
    s2_ff       <= s1_ff;
    c1_ff       <= {CS_N_I, RAS_N_I, CAS_N_I, WE_N_I, TERM_EN_I};
    c2_ff       <= c1_ff;
    clk_prev_ff <= s2_ff[1];
  end

  wire logic       edge_w  = s2_ff[1] & ~clk_prev_ff;
  wire logic       cke_w   = s2_ff[0];
  wire logic       term_w  = c2_ff[0];
  wire logic [3:0] cmd_w   = c2_ff[4:1];

  function automatic logic is_nop(input logic [3:0] c);
    is_nop = c[dlp_pkg::SEL_BIT] | (c == dlp_pkg::CMD_NOP);
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // state machine, stepped on link clock edges

  dlp_pkg::dlp_state_t state_ff;
  dlp_pkg::dlp_state_t nxt_state;
  logic             cke_prev_ff;
  logic             nxt_cke_prev;
  logic [dlp_pkg::CNT_W-1:0] cnt_ff;
  logic [dlp_pkg::CNT_W-1:0] nxt_cnt;
  logic [dlp_pkg::CNT_W-1:0] sr_tmr_ff;
  logic [dlp_pkg::CNT_W-1:0] nxt_sr_tmr;
  logic             ref_owed_ff;
  logic             nxt_ref_owed;
  logic             err_ff;
  logic             nxt_err;
  logic             reinit_ff;
  logic             nxt_reinit;
  logic             iref_ff;
  logic             nxt_iref;

  always_comb
  begin
    nxt_state    = state_ff;
    nxt_cke_prev = cke_prev_ff;
    nxt_cnt      = cnt_ff;
    nxt_sr_tmr   = sr_tmr_ff;
    nxt_ref_owed = ref_owed_ff;
    nxt_err      = err_ff;
    nxt_reinit   = reinit_ff;
    nxt_iref     = 1'b0;
    // self-refresh runs on the system clock, link clock may stop
    if (state_ff == dlp_pkg::ST_SELFREF)
    begin
      if (sr_tmr_ff != '1)
        nxt_sr_tmr = sr_tmr_ff + 1'b1;
      if (sr_tmr_ff == dlp_pkg::CNT_W'(IREF_CYC))
        nxt_iref = 1'b1;
    end
    if (edge_w)
    begin
      nxt_cke_prev = cke_w;
      if (cnt_ff != '1)
        nxt_cnt = cnt_ff + 1'b1;
      case (state_ff)
        dlp_pkg::ST_IDLE, dlp_pkg::ST_ACTIVE:
        begin
          if (cke_prev_ff && !cke_w)
          begin
            if (cmd_w == dlp_pkg::CMD_REFRESH && !ROW_OPEN_I)
            begin
              // termination on or refresh owed is flagged
              if (term_w || ref_owed_ff)
                nxt_err = 1'b1;
              nxt_state  = dlp_pkg::ST_SELFREF;
              nxt_sr_tmr = '0;
              nxt_cnt    = '0;
            end
            else if (is_nop(cmd_w))
            begin
              nxt_cnt = '0;
              if (!ROW_OPEN_I)
                nxt_state = dlp_pkg::ST_PPD;
              else if (PD_EXIT_SEL_I)
                nxt_state = dlp_pkg::ST_APD_SLOW;
              else
                nxt_state = dlp_pkg::ST_APD_FAST;
            end
            else
              nxt_reinit = 1'b1;
          end
          else if (cke_w)
          begin
            if (cmd_w == dlp_pkg::CMD_REFRESH)
              nxt_ref_owed = 1'b0;
            if (!cmd_w[dlp_pkg::SEL_BIT] && cmd_w == dlp_pkg::CMD_ACT)
              nxt_state = dlp_pkg::ST_ACTIVE;
            else if (!ROW_OPEN_I)
              nxt_state = dlp_pkg::ST_IDLE;
          end
        end
        // only clock enable is looked at
        dlp_pkg::ST_SELFREF:
        begin
          if (cke_w)
          begin
            nxt_cnt      = '0;
            nxt_ref_owed = 1'b1;
            nxt_state    = dlp_pkg::ST_SR_EXIT;
            if (sr_tmr_ff < dlp_pkg::CNT_W'(MIN_LOWPOWER_CYC))
              nxt_err = 1'b1;
          end
        end
        dlp_pkg::ST_SR_EXIT:
        begin
          if (cnt_ff < dlp_pkg::CNT_W'(dlp_pkg::SR_EXIT_NONREAD_LINK) && !is_nop(cmd_w))
            nxt_err = 1'b1;
          if (!cke_w)
            nxt_err = 1'b1;
          if (cnt_ff >= dlp_pkg::CNT_W'(dlp_pkg::SR_EXIT_READ_LINK - 1))
            nxt_state = dlp_pkg::ST_IDLE;
        end
        dlp_pkg::ST_PPD, dlp_pkg::ST_APD_FAST, dlp_pkg::ST_APD_SLOW:
        begin
          if (cke_w)
          begin
            if (!is_nop(cmd_w))
              nxt_err = 1'b1;
            nxt_cnt   = '0;
            nxt_state = dlp_pkg::ST_PD_EXIT;
          end
        end
        dlp_pkg::ST_PD_EXIT:
        begin
          nxt_state = ROW_OPEN_I ? dlp_pkg::ST_ACTIVE : dlp_pkg::ST_IDLE;
        end
        default:
          nxt_state = dlp_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state_ff    <= dlp_pkg::ST_IDLE;
      cke_prev_ff <= 1'b0;
      cnt_ff      <= '0;
      sr_tmr_ff   <= '0;
      ref_owed_ff <= 1'b0;
      err_ff      <= 1'b0;
      reinit_ff   <= 1'b0;
      iref_ff     <= 1'b0;
    end
    else
    begin
      state_ff    <= nxt_state;
      cke_prev_ff <= nxt_cke_prev;
      cnt_ff      <= nxt_cnt;
      sr_tmr_ff   <= nxt_sr_tmr;
      ref_owed_ff <= nxt_ref_owed;
      err_ff      <= nxt_err;
      reinit_ff   <= nxt_reinit;
      iref_ff     <= nxt_iref;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic [5:0] out_ff;
  logic [5:0] nxt_out;
  always_comb
  begin
    nxt_out = 6'h3F;
    case (nxt_state)
      // loop and clock gated in self-refresh
      dlp_pkg::ST_SELFREF:  nxt_out = 6'h00;
      dlp_pkg::ST_PPD:      nxt_out = 6'h02;
      dlp_pkg::ST_APD_SLOW: nxt_out = 6'h02;
      dlp_pkg::ST_APD_FAST: nxt_out = 6'h03;
      // commands return after the non-read delay
      dlp_pkg::ST_SR_EXIT:
        nxt_out = (nxt_cnt >= dlp_pkg::CNT_W'(dlp_pkg::SR_EXIT_NONREAD_LINK)) ? 6'h0F : 6'h07;
      dlp_pkg::ST_PD_EXIT:  nxt_out = 6'h07;
      default:              nxt_out = 6'h3F;
    endcase
  end
  always_ff @(posedge SYS_CLK_I)
  begin
    if (!RST_N_I)
      out_ff <= 6'h3F;
    else
      out_ff <= nxt_out;
  end

  // out bits: 0 loop, 1 clock, 2 buffers, 3 cmd, 4 read, 5 spare
  assign STATE_O        = state_ff;
  assign DLL_EN_O       = out_ff[0];
  assign INT_CLK_EN_O   = out_ff[1];
  assign BUF_EN_O       = out_ff[2];
  assign CMD_ALLOWED_O  = out_ff[3];
  assign READ_ALLOWED_O = out_ff[4];
  assign INT_REFRESH_O  = iref_ff;
  assign CMD_ERR_O      = err_ff;
  assign REINIT_REQ_O   = reinit_ff;

  //////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence s_sr_enter;
    state_ff != dlp_pkg::ST_SELFREF ##1 state_ff == dlp_pkg::ST_SELFREF;
  endsequence
  property p_sr_gate;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    s_sr_enter |-> !DLL_EN_O && !INT_CLK_EN_O;
  endproperty
  a_sr_gate: assert property (p_sr_gate) else $error("loop on in self-refresh");
  property p_fast_dll;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    state_ff == dlp_pkg::ST_APD_FAST |-> DLL_EN_O && !BUF_EN_O;
  endproperty
  a_fast_dll: assert property (p_fast_dll) else $error("fast power-down loop");
  property p_slow_dll;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    state_ff == dlp_pkg::ST_PPD || state_ff == dlp_pkg::ST_APD_SLOW |-> !DLL_EN_O;
  endproperty
  a_slow_dll: assert property (p_slow_dll) else $error("loop on in power-down");
  property p_sr_hold;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    state_ff == dlp_pkg::ST_SELFREF && !cke_w |=> state_ff == dlp_pkg::ST_SELFREF;
  endproperty
  a_sr_hold: assert property (p_sr_hold) else $error("left self-refresh");
  property p_iref;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    state_ff == dlp_pkg::ST_SELFREF && sr_tmr_ff == dlp_pkg::CNT_W'(IREF_CYC)
      |=> INT_REFRESH_O;
  endproperty
  a_iref: assert property (p_iref) else $error("internal refresh missing");
  property p_pd_exit;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    state_ff == dlp_pkg::ST_PPD && edge_w && cke_w |=> state_ff == dlp_pkg::ST_PD_EXIT;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("power-down exit missed");
  property p_read_block;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    state_ff == dlp_pkg::ST_SR_EXIT |-> !READ_ALLOWED_O &&
      CMD_ALLOWED_O == (cnt_ff >= dlp_pkg::CNT_W'(dlp_pkg::SR_EXIT_NONREAD_LINK));
  endproperty
  a_read_block: assert property (p_read_block) else $error("read during exit");
  property p_err_sticky;
    @(posedge SYS_CLK_I) disable iff (!RST_N_I)
    CMD_ERR_O |=> CMD_ERR_O;
  endproperty
  a_err_sticky: assert property (p_err_sticky) else $error("error flag dropped");
endmodule
`default_nettype wire

/* design/dlp_pkg.sv */
`default_nettype none
package dlp_pkg;
  // low-power state of the device
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ACTIVE,
    ST_SELFREF,
    ST_SR_EXIT,
    ST_PPD,
    ST_APD_FAST,
    ST_APD_SLOW,
    ST_PD_EXIT
  } dlp_state_t;

  // decoded command, active-low strobes in order cs, ras, cas, we
  localparam logic [3:0] CMD_NOP     = 4'h7;
  localparam logic [3:0] CMD_REFRESH = 4'h1;
  localparam logic [3:0] CMD_ACT     = 4'h3;
  localparam logic [3:0] CMD_PRE     = 4'h2;
  localparam logic [3:0] CMD_MRS     = 4'h0;
  localparam int unsigned SEL_BIT    = 3;

  // clock period and device delays
  localparam int unsigned CLK_PERIOD_NS       = 50;
  localparam int unsigned MIN_LOWPOWER_NS     = 7500;
  localparam int unsigned MIN_LOWPOWER_CYC    =
    (MIN_LOWPOWER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SR_INTERNAL_REF_CYC = MIN_LOWPOWER_CYC / 2;
  localparam int unsigned SR_EXIT_NONREAD_LINK = 10;
  localparam int unsigned SR_EXIT_READ_LINK    = 200;
  localparam int unsigned CNT_W                = 16;
endpackage
`default_nettype wire

/* dv/dlp_core_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module dlp_core_tb_top;
  localparam int unsigned MIN_LP = 20;
  logic       sys_clk;
  logic       rst_n;
  logic       link_clk;
  logic       cke;
  logic       cs_n;
  logic       ras_n;
  logic       cas_n;
  logic       we_n;
  logic       term_en;
  logic       pd_sel;
  logic       row_open;
  logic [2:0] state;
  logic       dll_en;
  logic       int_clk_en;
  logic       buf_en;
  logic       int_ref;
  logic       cmd_ok;
  logic       read_ok;
  logic       cmd_err;
  logic       reinit;
  logic       seen;
  logic [1:0] mode [3] = '{2'h1, 2'h3, 2'h0};
  int         num_errors = 0;
  int         checks = 0;

  dlp_ctrl_model i_dlp_ctrl_model (.sys_clk_i(sys_clk), .link_clk_o(link_clk),
    .cke_o(cke), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n), .we_n_o(we_n),
    .term_en_o(term_en));
  dlp_core #(.MIN_LOWPOWER_CYC(MIN_LP)) i_dlp_core (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
    .LINK_CLK_I(link_clk), .CKE_I(cke), .CS_N_I(cs_n), .RAS_N_I(ras_n), .CAS_N_I(cas_n),
    .WE_N_I(we_n), .TERM_EN_I(term_en), .PD_EXIT_SEL_I(pd_sel), .ROW_OPEN_I(row_open),
    .STATE_O(state), .DLL_EN_O(dll_en), .INT_CLK_EN_O(int_clk_en), .BUF_EN_O(buf_en),
    .INT_REFRESH_O(int_ref), .CMD_ALLOWED_O(cmd_ok), .READ_ALLOWED_O(read_ok),
    .CMD_ERR_O(cmd_err), .REINIT_REQ_O(reinit));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_st(input dlp_pkg::dlp_state_t exp);
    check(8'(state), 8'(exp));
  endtask
  task automatic results();
    if (num_errors == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // a hang anywhere ends the run as a mismatch
  initial
  begin
    #2ms;
    num_errors++;
    results();
  end
  ////////////////////////////////////////////////////////////////
  initial
  begin
    rst_n = 1'b0;
    pd_sel = 1'b0;
    row_open = 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    @(negedge sys_clk);
    chk_st(dlp_pkg::ST_IDLE);
    check(8'({dll_en, int_clk_en, buf_en, cmd_ok, read_ok, cmd_err, reinit}), 8'h7C);
    // nop, plain deselect, deselect with strobes low
    foreach (mode[i])
    begin
      i_dlp_ctrl_model.cmd(i == 0 ? dlp_pkg::CMD_NOP : (i == 1 ? 4'hF : 4'h8), 1'b1, 3);
      chk_st(dlp_pkg::ST_IDLE);
      check(8'(cmd_err), 8'h0);
    end
    // active fast, active slow, then precharge power-down
    foreach (mode[i])
    begin
      @(posedge sys_clk);
      pd_sel <= mode[i][1];
      row_open <= mode[i][0];
      i_dlp_ctrl_model.cmd(dlp_pkg::CMD_NOP, 1'b0, 3);
      chk_st(mode[i][0] ? (mode[i][1] ? dlp_pkg::ST_APD_SLOW : dlp_pkg::ST_APD_FAST)
                        : dlp_pkg::ST_PPD);
      check(8'({dll_en, buf_en}), 8'({mode[i][0] & ~mode[i][1], 1'b0}));
      i_dlp_ctrl_model.cmd(4'hF, 1'b1, 3);
      chk_st(mode[i][0] ? dlp_pkg::ST_ACTIVE : dlp_pkg::ST_IDLE);
      check(8'({dll_en, buf_en, cmd_err}), 8'h6);
    end
    i_dlp_ctrl_model.cmd(dlp_pkg::CMD_REFRESH, 1'b0, 1);
    chk_st(dlp_pkg::ST_SELFREF);
    check(8'({dll_en, int_clk_en, buf_en}), 8'h0);
    seen = 1'b0;
    repeat (MIN_LP)
    begin
      @(negedge sys_clk);
      seen = seen | (int_ref === 1'b1);
    end
    check(8'(seen), 8'h1);
    // stop the link clock and wiggle everything but cke
    i_dlp_ctrl_model.raw(4'h0, 1'b1, 1'b0);
    repeat (40) @(negedge sys_clk);
    chk_st(dlp_pkg::ST_SELFREF);
    check(8'({cmd_err, reinit, dll_en}), 8'h0);
    i_dlp_ctrl_model.raw(4'hF, 1'b0, 1'b1);
    i_dlp_ctrl_model.cmd(4'hF, 1'b0, 3);
    i_dlp_ctrl_model.cmd(4'hF, 1'b1, 3);
    chk_st(dlp_pkg::ST_SR_EXIT);
    check(8'({dll_en, int_clk_en, buf_en, cmd_ok, read_ok}), 8'h1C);
    i_dlp_ctrl_model.cmd(4'hF, 1'b1, 10);
    check(8'({cmd_ok, read_ok}), 8'h2);
    i_dlp_ctrl_model.cmd(4'hF, 1'b1, 176);
    chk_st(dlp_pkg::ST_SR_EXIT);
    check(8'(read_ok), 8'h0);
    i_dlp_ctrl_model.cmd(4'hF, 1'b1, 14);
    chk_st(dlp_pkg::ST_IDLE);
    check(8'({cmd_ok, read_ok, cmd_err}), 8'h6);
    // owed auto-refresh first, then a clean second self-refresh and exit
    i_dlp_ctrl_model.cmd(dlp_pkg::CMD_REFRESH, 1'b1, 3);
    i_dlp_ctrl_model.cmd(dlp_pkg::CMD_REFRESH, 1'b0, 3);
    chk_st(dlp_pkg::ST_SELFREF);
    check(8'(cmd_err), 8'h0);
    i_dlp_ctrl_model.cmd(4'hF, 1'b1, 3);
    i_dlp_ctrl_model.cmd(4'hF, 1'b1, 200);
    chk_st(dlp_pkg::ST_IDLE);
    check(8'(cmd_err), 8'h0);
    // faults: a command on power-down exit, then cke dropped with a command
    i_dlp_ctrl_model.cmd(dlp_pkg::CMD_NOP, 1'b0, 3);
    chk_st(dlp_pkg::ST_PPD);
    i_dlp_ctrl_model.cmd(dlp_pkg::CMD_ACT, 1'b1, 3);
    check(8'({cmd_err, reinit}), 8'h2);
    i_dlp_ctrl_model.cmd(dlp_pkg::CMD_ACT, 1'b0, 3);
    check(8'(reinit), 8'h1);
    results();
  end
endmodule
`default_nettype wire

/* dv/dlp_ctrl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dlp_ctrl_model (
  input  wire logic sys_clk_i,   // bench system clock
  output var logic  link_clk_o,  // memory clock to device
  output var logic  cke_o,       // clock enable
  output var logic  cs_n_o,      // chip select, active low
  output var logic  ras_n_o,     // row strobe, active low
  output var logic  cas_n_o,     // column strobe, active low
  output var logic  we_n_o,      // write strobe, active low
  output var logic  term_en_o    // termination enable
);
  logic run;
  ////////////////////////////////////////////////////////////////
  // clock halts low, only in self-refresh
  initial
  begin
    run = 1'b1;
    link_clk_o = 1'b0;
    #37;
    forever
    begin
      #200;
      link_clk_o = run ? ~link_clk_o : 1'b0;
    end
  end
  // termination kept off unless a test says otherwise
  initial
  begin
    cke_o = 1'b1;
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} = 4'hF;
    term_en_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////
  // callers hold each cke level for n rising link edges
  // pins move half a link period before the sampling edge
  // no read or write, so no burst
  task automatic cmd(input logic [3:0] c, input logic cke, input int n);
    @(negedge link_clk_o);
    @(posedge sys_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    cke_o <= cke;
    repeat (n) @(posedge link_clk_o);
    repeat (6) @(posedge sys_clk_i);
    // hand back where the outputs have settled
    @(negedge sys_clk_i);
  endtask
  // raw pin drive, used only while the link clock may be stopped
  task automatic raw(input logic [3:0] c, input logic t, input logic r);
    @(posedge sys_clk_i);
    {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= c;
    term_en_o <= t;
    run = r;
  endtask
endmodule
`default_nettype wire
